// file: csc_defs.svh
// register indices, field positions, reset values and widths of the statistics counter bank
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_IDX_W                     10
`define CSC_TALLY_W                   16
`define CSC_BYTE_W                    8
`define CSC_NUM_TALLY                 5

`define CSC_IDX_P0_BAD_LINE_UPPER     10'h096
`define CSC_IDX_P0_BAD_LINE_LOWER     10'h097
`define CSC_IDX_P1_FRAME_UPPER        10'h098
`define CSC_IDX_P1_FRAME_LOWER        10'h099
`define CSC_IDX_P1_BAD_FRAME_UPPER    10'h09a
`define CSC_IDX_P1_BAD_FRAME_LOWER    10'h09b
`define CSC_IDX_P1_LINE_UPPER         10'h09c
`define CSC_IDX_P1_LINE_LOWER         10'h09d
`define CSC_IDX_P1_BAD_LINE_UPPER     10'h09e
`define CSC_IDX_P1_BAD_LINE_LOWER     10'h09f
`define CSC_IDX_TALLY_FIRST           `CSC_IDX_P0_BAD_LINE_UPPER
`define CSC_IDX_TALLY_LAST            `CSC_IDX_P1_BAD_LINE_LOWER
`define CSC_IDX_STATUS                10'h0a0
`define CSC_IDX_MASK                  10'h0a1
`define CSC_IDX_CTRL                  10'h0a2

`define CSC_RST_BYTE                  8'h00
`define CSC_RST_TALLY                 16'h0000
`define CSC_RST_EVT                   5'h00
`define CSC_RST_ENABLE                5'h1f
`define CSC_TALLY_MAX                 16'hffff
`define CSC_TALLY_ONE                 16'h0001
`define CSC_CTRL_WIPE_BIT             7
`define CSC_EVT_MSB                   4
`define CSC_RDATA_ZERO                32'h0000_0000

`endif

// file: csc_pkg.sv
// types shared by the statistics counter bank
package csc_pkg;

    typedef logic [15:0] csc_tally_type;
    typedef logic [7:0]  csc_byte_type;
    typedef logic [9:0]  csc_index_type;
    typedef logic [2:0]  csc_slot_type;
    typedef logic [4:0]  csc_evt_type;

    typedef enum logic [2:0] {
        CSC_TALLY_P0_BAD_LINE  = 3'h0,
        CSC_TALLY_P1_FRAME     = 3'h1,
        CSC_TALLY_P1_BAD_FRAME = 3'h2,
        CSC_TALLY_P1_LINE      = 3'h3,
        CSC_TALLY_P1_BAD_LINE  = 3'h4
    } csc_tally_id_type;

endpackage

// file: csc_stat_bank.sv
// statistics counter bank for the two csi-2 output ports, apb slave
`timescale 1ns/10ps
`include "csc_defs.svh"
module csc_stat_bank (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  port0_line_done,
    input  wire logic                  port0_line_bad,
    input  wire logic                  port1_frame_done,
    input  wire logic                  port1_frame_bad,
    input  wire logic                  port1_line_done,
    input  wire logic                  port1_line_bad,
    output logic                       irq
);
    import csc_pkg::*;

    // the tally registers sit in pairs: even index upper byte, odd index lower byte
    function automatic logic is_tally(input csc_index_type idx);
        is_tally = (idx >= `CSC_IDX_TALLY_FIRST) && (idx <= `CSC_IDX_TALLY_LAST);
    endfunction

    function automatic csc_slot_type slot_of(input csc_index_type idx);
        csc_index_type off;
        off     = idx - `CSC_IDX_TALLY_FIRST;
        slot_of = off[3:1];
    endfunction

    function automatic logic is_upper(input csc_index_type idx);
        is_upper = is_tally(idx) && !idx[0];
    endfunction

    function automatic logic is_mapped(input csc_index_type idx);
        is_mapped = is_tally(idx) || (idx == `CSC_IDX_STATUS) || (idx == `CSC_IDX_MASK)
                    || (idx == `CSC_IDX_CTRL);
    endfunction

    csc_index_type  idx;
    logic           aligned;
    logic           setup_phase;
    logic           rd_setup;
    logic           wr_access;
    logic           wr_lane0;
    logic           wipe;
    csc_evt_type    bump;
    csc_evt_type    take;
    csc_evt_type    wrap;
    csc_tally_type  tally_w [`CSC_NUM_TALLY];
    csc_byte_type   lower_w [`CSC_NUM_TALLY];
    csc_evt_type    status_q;
    csc_evt_type    status_d;
    csc_evt_type    mask_q;
    csc_evt_type    enable_q;
    csc_byte_type   rd_val;
    logic           err_now;
    logic [31:0]    prdata_q;
    logic           pslverr_q;

    assign idx         = paddr[11:2];
    assign aligned     = (paddr[1:0] == 2'h0);
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    assign wr_lane0    = wr_access && pstrb[0] && aligned;

    // reads act in the setup cycle so the returned byte, the snapshot and the
    // clear all see the same counter value; apb reads cannot be withdrawn
    assign rd_setup    = setup_phase && !pwrite && aligned;

    // a write of one to the wipe bit clears every counter and snapshot at once
    assign wipe        = wr_lane0 && (idx == `CSC_IDX_CTRL) && pwdata[`CSC_CTRL_WIPE_BIT];

    // event inputs come from the transmitters on this same clock, so no synchroniser
    always_comb
    begin
        bump                          = `CSC_RST_EVT;
        bump[CSC_TALLY_P0_BAD_LINE]   = port0_line_done && port0_line_bad;
        bump[CSC_TALLY_P1_FRAME]      = port1_frame_done;
        bump[CSC_TALLY_P1_BAD_FRAME]  = port1_frame_done && port1_frame_bad;
        bump[CSC_TALLY_P1_LINE]       = port1_line_done;
        bump[CSC_TALLY_P1_BAD_LINE]   = port1_line_done && port1_line_bad;
        bump                          = bump & enable_q;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CSC_NUM_TALLY; gi++)
        begin : g_tally
            assign take[gi] = rd_setup && is_upper(idx) && (slot_of(idx) == csc_slot_type'(gi));

            csc_tally_cell u_cell (
                .pclk    (pclk),
                .presetn (presetn),
                .bump    (bump[gi]),
                .take    (take[gi]),
                .wipe    (wipe),
                .tally_q (tally_w[gi]),
                .lower_q (lower_w[gi]),
                .wrap    (wrap[gi])
            );
        end
    endgenerate

    always_comb
    begin
        rd_val = `CSC_RST_BYTE;
        if (is_tally(idx))
        begin
            if (is_upper(idx))
            begin
                rd_val = tally_w[slot_of(idx)][15:8];
            end
            else
            begin
                rd_val = lower_w[slot_of(idx)];
            end
        end
        else if (idx == `CSC_IDX_STATUS)
        begin
            rd_val = {3'h0, status_q};
        end
        else if (idx == `CSC_IDX_MASK)
        begin
            rd_val = {3'h0, mask_q};
        end
        else if (idx == `CSC_IDX_CTRL)
        begin
            rd_val = {3'h0, enable_q};
        end
    end

    assign err_now = !aligned || !is_mapped(idx);

    // counter wrap events: set wins over the read-clear in the same cycle
    always_comb
    begin
        status_d = status_q;
        if (rd_setup && (idx == `CSC_IDX_STATUS))
        begin
            status_d = `CSC_RST_EVT;
        end
        status_d = status_d | wrap;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= `CSC_RST_EVT;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= `CSC_RST_EVT;
        end
        else if (wr_lane0 && (idx == `CSC_IDX_MASK))
        begin
            mask_q <= pwdata[`CSC_EVT_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= `CSC_RST_ENABLE;
        end
        else if (wr_lane0 && (idx == `CSC_IDX_CTRL))
        begin
            enable_q <= pwdata[`CSC_EVT_MSB:0];
        end
    end

    // read data and error are fixed at setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= `CSC_RDATA_ZERO;
        end
        else if (setup_phase)
        begin
            prdata_q <= (pwrite || err_now) ? `CSC_RDATA_ZERO : {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_q <= 1'b0;
        end
        else if (setup_phase)
        begin
            pslverr_q <= err_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status_d & mask_q);
        end
    end

    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

endmodule // csc_stat_bank

// file: csc_stat_bank_monitor.sv
// port assertions for the statistics counter bank
`timescale 1ns/10ps
`include "csc_defs.svh"
module csc_stat_bank_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        port0_line_done,
    input wire logic        port1_frame_done,
    input wire logic        port1_line_done,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, rd_acc, wr_acc, rd_set, in_bank, ev;
    assign acc = psel && penable;
    assign rd_acc = acc && !pwrite;
    assign wr_acc = acc && pwrite;
    assign rd_set = psel && !penable && !pwrite;
    assign in_bank = paddr[11:2] >= `CSC_IDX_TALLY_FIRST && paddr[11:2] <= `CSC_IDX_TALLY_LAST;
    assign ev = port0_line_done || port1_frame_done || port1_line_done;
    sequence s_up_acc;
        rd_acc && in_bank && paddr[2:0] == 3'h0;
    endsequence
    sequence s_lo_acc;
        rd_acc && in_bank && paddr[2:0] == 3'h4;
    endsequence
    // only a back-to-back repeat is checked: a gap would let new events in
    sequence s_again;
        rd_set && $stable(paddr);
    endsequence
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_byte;
        rd_acc && in_bank && paddr[1:0] == 2'h0 |-> prdata[31:8] == 24'h000000 && !pslverr;
    endproperty
    a_byte: assert property (p_byte) else $error("counter read wider than a byte");
    property p_clear;
        s_up_acc ##1 s_again |=> prdata == 32'h0000_0000;
    endproperty
    a_clear: assert property (p_clear) else $error("upper read did not clear");
    property p_hold;
        s_lo_acc ##1 s_again |=> prdata == $past(prdata, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("lower read changed snapshot");
    property p_refuse;
        acc && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_refuse: assert property (p_refuse) else $error("misaligned access not refused");
    property p_reset;
        $rose(presetn) |-> prdata == 32'h0000_0000 && !irq;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not clear after reset");
    property p_irq_up;
        $rose(irq) |-> $past(ev) || $past(wr_acc, 2);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
    property p_irq_down;
        $fell(irq) |-> $past(rd_set && paddr[11:2] == `CSC_IDX_STATUS) || $past(wr_acc, 2);
    endproperty
    a_irq_down: assert property (p_irq_down) else $error("irq fell without cause");
endmodule // csc_stat_bank_monitor
bind csc_stat_bank csc_stat_bank_monitor u_monitor (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port0_line_done(port0_line_done), .port1_frame_done(port1_frame_done), .port1_line_done(port1_line_done),
    .irq(irq));

// file: csc_tally_cell.sv
// one 16-bit statistics counter with its read-clear and low-byte snapshot
`timescale 1ns/10ps
`include "csc_defs.svh"
module csc_tally_cell (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  bump,
    input  wire logic                  take,
    input  wire logic                  wipe,
    output csc_pkg::csc_tally_type     tally_q,
    output csc_pkg::csc_byte_type      lower_q,
    output logic                       wrap
);
    import csc_pkg::*;

    csc_tally_type tally_d;

    // an increment landing on the clearing read is dropped
    always_comb
    begin
        tally_d = tally_q;
        if (take || wipe)
        begin
            tally_d = `CSC_RST_TALLY;
        end
        else if (bump)
        begin
            tally_d = tally_q + `CSC_TALLY_ONE;
        end
    end

    assign wrap = bump && !take && !wipe && (tally_q == `CSC_TALLY_MAX);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tally_q <= `CSC_RST_TALLY;
        end
        else
        begin
            tally_q <= tally_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lower_q <= `CSC_RST_BYTE;
        end
        else if (wipe)
        begin
            lower_q <= `CSC_RST_BYTE;
        end
        else if (take)
        begin
            lower_q <= tally_q[7:0];
        end
    end

endmodule // csc_tally_cell

// file: test_csc_stat_bank.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/10ps
`include "csc_defs.svh"
module test_csc_stat_bank;
    import csc_pkg::*;
    typedef struct {logic [5:0] pat; int n; csc_tally_type [0:4] t;} csc_row_type;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [5:0]  ev = 6'h00;
    logic        pready, pslverr, irq, er;
    logic [31:0] prdata, rd;
    int          n_errors = 0;
    int          checks = 0;
    csc_row_type rows [6] = '{'{6'h03, 3, '{16'h3, 16'h0, 16'h0, 16'h0, 16'h0}},
        '{6'h01, 4, '{default: 16'h0}}, '{6'h04, 300, '{16'h0, 16'h12c, 16'h0, 16'h0, 16'h0}},
        '{6'h0c, 2, '{16'h0, 16'h2, 16'h2, 16'h0, 16'h0}}, '{6'h30, 5, '{16'h0, 16'h0, 16'h0, 16'h5, 16'h5}},
        '{6'h2a, 4, '{default: 16'h0}}};
    always #12.5 pclk = ~pclk;
    csc_stat_bank dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .port0_line_done(ev[0]), .port0_line_bad(ev[1]), .port1_frame_done(ev[2]), .port1_frame_bad(ev[3]),
        .port1_line_done(ev[4]), .port1_line_bad(ev[5]), .irq(irq));
    task automatic conclude();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp32(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp1(string what, logic exp, logic got);
        cmp32(what, {31'h0, exp}, {31'h0, got});
    endtask
    // a non-last transfer keeps psel up so the next setup follows at once
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic last);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
        begin
            n_errors++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (last)
        begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic rdc(logic [11:0] a, logic [31:0] e, logic last);
        apb(1'b0, a, 32'h0, last);
        cmp32("prdata", e, rd);
    endtask
    task automatic tallies(csc_tally_type [0:4] t);
        logic [11:0] a;
        for (int i = 0; i < 5; i++)
        begin
            a = {`CSC_IDX_TALLY_FIRST, 2'b00} + 12'(i * 8);
            // every upper read takes a fresh snapshot, so the lower byte is read before the next upper
            rdc(a, {24'h0, t[i][15:8]}, 1'b0);
            rdc(a + 12'h4, {24'h0, t[i][7:0]}, 1'b0);
            rdc(a + 12'h4, {24'h0, t[i][7:0]}, 1'b0);
            rdc(a, 32'h0, 1'b0);
            rdc(a, 32'h0, i == 4);
        end
    endtask
    task automatic pulse(logic [5:0] p, int n);
        ev <= p;
        repeat (n) @(posedge pclk);
        ev <= 6'h00;
    endtask
    task automatic wait_irq(logic v);
        int k;
        k = 0;
        while (irq !== v && k < 8)
        begin
            @(posedge pclk);
            k++;
        end
        cmp1("irq", v, irq);
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp1("irq", 1'b0, irq);
        tallies('{default: 16'h0});
        foreach (rows[r])
        begin
            pulse(rows[r].pat, rows[r].n);
            tallies(rows[r].t);
        end
        // events held across a clearing read: only the access-end edge counts
        ev <= 6'h03;
        rdc(12'h258, 32'h0, 1'b0);
        ev <= 6'h00;
        tallies('{16'h1, 16'h0, 16'h0, 16'h0, 16'h0});
        apb(1'b0, 12'h800, 32'h0, 1'b1);
        cmp1("pslverr", 1'b1, er);
        rdc(12'h259, 32'h0, 1'b1);
        cmp1("pslverr", 1'b1, er);
        pulse(6'h10, 65536);
        repeat (4) @(posedge pclk);
        cmp1("irq", 1'b0, irq);
        apb(1'b1, {`CSC_IDX_MASK, 2'b00}, 32'h0000_0008, 1'b1);
        wait_irq(1'b1);
        rdc({`CSC_IDX_STATUS, 2'b00}, 32'h0000_0008, 1'b1);
        wait_irq(1'b0);
        tallies('{default: 16'h0});
        // wipe clears every counter; afterwards only counter 0 stays enabled
        pulse(6'h3f, 3);
        apb(1'b1, {`CSC_IDX_CTRL, 2'b00}, 32'h0000_0081, 1'b1);
        rdc({`CSC_IDX_CTRL, 2'b00}, 32'h0000_0001, 1'b1);
        pulse(6'h3f, 2);
        tallies('{16'h2, 16'h0, 16'h0, 16'h0, 16'h0});
        // reset in mid-run while a counter holds a value
        pulse(6'h3f, 3);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp1("irq", 1'b0, irq);
        rdc({`CSC_IDX_MASK, 2'b00}, 32'h0000_0000, 1'b0);
        rdc({`CSC_IDX_CTRL, 2'b00}, 32'h0000_001f, 1'b0);
        tallies('{default: 16'h0});
        conclude();
    end
endmodule // test_csc_stat_bank
